// [design/pios_map.svh]
// Constants for the programmed I/O device-select block: opcodes, widths, reset values.
// Assumes inclusion by bare name from the design files; holds definitions only.
// How it works
// - An eight-bit select register names one of 256 I/O targets.
// - A target's ready flag at 1 means it can take or give a word.
// - Waiting transfers test ready and repeat without transfer until it reads 1.
// - While waiting, the whole program is stalled until ready becomes 1.
// - The ready wait has no timeout; a never-ready target stalls forever.
// - Output copies the pad bus word onto the shared bus to the target.
// - Input takes the target's bus word onto the pad bus that instruction.
// - Plain input and output transfer without looking at ready.
// - Transfer-then-reselect ops move the word, then load select from scratch result.
// - Combined ops wait for ready, transfer, then reload select from scratch result.
// - Panel holds lamp, switch and function registers, each sixteen bits.
// - Processor writes lamps and reads switches; the host owns all else.
// - Host can examine and modify processor state and control execution through panel.
// - The panel operation chosen follows the function register control bits.
// - A select change takes effect from the next instruction cycle.
// - Sense ops gate condition A or B into ready; waiting forms keep gating.
`ifndef PIOS_MAP_SVH
`define PIOS_MAP_SVH

// ----------
// Widths and reset values
// ----------
`define PIOS_SEL_W          8
`define PIOS_PANEL_W        16
`define PIOS_SEL_RST        8'h00
`define PIOS_PANEL_RST      16'h0000
`define PIOS_OP_W           4

// ----------
// Operation codes on the op port
// ----------
`define PIOS_OP_NOP         4'h0
`define PIOS_OP_IN          4'h1
`define PIOS_OP_OUT         4'h2
`define PIOS_OP_WAIT_IN     4'h3
`define PIOS_OP_WAIT_OUT    4'h4
`define PIOS_OP_IN_RESEL    4'h5
`define PIOS_OP_OUT_RESEL   4'h6
`define PIOS_OP_WIN_RESEL   4'h7
`define PIOS_OP_WOUT_RESEL  4'h8
`define PIOS_OP_LOAD_SEL    4'h9
`define PIOS_OP_SENSE_A     4'ha
`define PIOS_OP_WSENSE_A    4'hb
`define PIOS_OP_SENSE_B     4'hc
`define PIOS_OP_WSENSE_B    4'hd
`define PIOS_OP_LAMP_WR     4'he
`define PIOS_OP_SWITCH_RD   4'hf

// ----------
// Wishbone word offsets (byte addresses)
// ----------
`define PIOS_ADR_W          4
`define PIOS_ADR_SWITCH     4'h0
`define PIOS_ADR_LAMP       4'h4
`define PIOS_ADR_FUNC       4'h8
`define PIOS_ADR_STATUS     4'hc

// ----------
// Function register control bits
// ----------
`define PIOS_FN_STOP        0
`define PIOS_FN_START       1
`define PIOS_FN_CONT        2
`define PIOS_FN_STEP        3
`define PIOS_FN_RESET       4
`define PIOS_FN_EXAM        5
`define PIOS_FN_DEP         6
`define PIOS_FN_BREAK       7

`endif

// [design/pios_panel.sv]
// Console panel: lamp, switch and function registers plus operation select.
// Assumes the host side reaches it through the top module's Wishbone slave.
`timescale 1ns/1ns
`include "pios_map.svh"
module pios_panel #(
   parameter int PANEL_W = `PIOS_PANEL_W
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   // Host writes
   input  wire logic                 host_sw_we,
   input  wire logic                 host_fn_we,
   input  wire logic [PANEL_W-1:0]   host_wdata,
   // Processor lamp write
   input  wire logic                 cpu_lamp_we,
   input  wire logic [PANEL_W-1:0]   cpu_lamp_data,
   // Register contents
   output logic      [PANEL_W-1:0]   lamp_display_reg,
   output logic      [PANEL_W-1:0]   switch_entry_reg,
   output logic      [PANEL_W-1:0]   panel_function_reg,
   // Selected panel operation
   output pios_pkg::pios_pnl_e       panel_op
);

   if (PANEL_W < 8) $error("panel width too small for control bits");

   // Switches and function belong to the host only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         switch_entry_reg   <= `PIOS_PANEL_RST;
         panel_function_reg <= `PIOS_PANEL_RST;
      end else begin
         if (host_sw_we) switch_entry_reg <= host_wdata;
         if (host_fn_we) panel_function_reg <= host_wdata;
      end
   end

   // Lamps are written by the processor only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lamp_display_reg <= `PIOS_PANEL_RST;
      end else if (cpu_lamp_we) begin
         lamp_display_reg <= cpu_lamp_data;
      end
   end

   // Priority: reset and stop outrank the rest, since they act while running
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         panel_op <= pios_pkg::PIOS_PNL_IDLE;
      end else if (panel_function_reg[`PIOS_FN_RESET]) begin
         panel_op <= pios_pkg::PIOS_PNL_RESET;
      end else if (panel_function_reg[`PIOS_FN_STOP]) begin
         panel_op <= pios_pkg::PIOS_PNL_STOP;
      end else if (panel_function_reg[`PIOS_FN_START]) begin
         panel_op <= pios_pkg::PIOS_PNL_START;
      end else if (panel_function_reg[`PIOS_FN_STEP]) begin
         panel_op <= pios_pkg::PIOS_PNL_STEP;
      end else if (panel_function_reg[`PIOS_FN_DEP]) begin
         panel_op <= pios_pkg::PIOS_PNL_DEP;
      end else if (panel_function_reg[`PIOS_FN_EXAM]) begin
         panel_op <= pios_pkg::PIOS_PNL_EXAM;
      end else begin
         panel_op <= pios_pkg::PIOS_PNL_IDLE;
      end
   end

endmodule

// [design/pios_pkg.sv]
// Types shared by the programmed I/O select block.
// Assumes pios_map.svh is on the include path.
`include "pios_map.svh"
package pios_pkg;

   // Decoded view of one instruction's I/O field
   typedef struct packed {
      logic is_in;
      logic is_out;
      logic waits;
      logic resel;
      logic sense;
      logic cond_b;
   } pios_dec_s;

   // Panel operation chosen from function bits
   typedef enum logic [2:0] {
      PIOS_PNL_IDLE,
      PIOS_PNL_STOP,
      PIOS_PNL_START,
      PIOS_PNL_STEP,
      PIOS_PNL_RESET,
      PIOS_PNL_EXAM,
      PIOS_PNL_DEP
   } pios_pnl_e;

endpackage

// [design/pios_top.sv]
// Programmed I/O device select, ready wait and data path, with panel access.
// Assumes one instruction per mclk cycle offered on op/op_valid while not stalled,
// and a classic Wishbone host that owns the panel.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`include "pios_map.svh"
module pios_top #(
   parameter int SEL_W   = `PIOS_SEL_W,
   parameter int DATA_W  = 16,
   parameter int PANEL_W = `PIOS_PANEL_W
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   // Instruction side
   input  wire logic                 op_valid,
   input  wire logic [`PIOS_OP_W-1:0] op,
   input  wire logic [SEL_W-1:0]     scratch_function_result,
   input  wire logic [DATA_W-1:0]    pad_bus,
   output logic                      stall,
   output logic                      op_done,
   output logic [DATA_W-1:0]         pad_bus_in,
   output logic                      pad_bus_in_valid,
   // Shared I/O bus to targets
   output logic [SEL_W-1:0]          io_target_select_reg,
   output logic [DATA_W-1:0]         shared_io_bus_out,
   output logic                      shared_io_bus_oe,
   output logic                      io_in_strobe,
   input  wire logic [DATA_W-1:0]    shared_io_bus_alt,
   input  wire logic                 target_ready_flag,
   input  wire logic                 cond_a,
   input  wire logic                 cond_b,
   // Panel status
   output logic [PANEL_W-1:0]        lamps,
   output logic [2:0]                panel_op_code,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [`PIOS_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   output logic                      wb_err_o
);

   if (SEL_W != 8) $error("select register must be eight bits");
   if (DATA_W < PANEL_W) $error("data width below panel width");
   if (PANEL_W != 16) $error("panel registers are sixteen bits");

   // ----------
   // Decode
   // ----------

   // Used for the fresh op and the held op alike
   function automatic pios_pkg::pios_dec_s decode(input logic [`PIOS_OP_W-1:0] c);
      pios_pkg::pios_dec_s d;
      d = '0;
      case (c)
         `PIOS_OP_IN:         d.is_in = 1'b1;
         `PIOS_OP_OUT:        d.is_out = 1'b1;
         `PIOS_OP_WAIT_IN:    begin d.is_in = 1'b1; d.waits = 1'b1; end
         `PIOS_OP_WAIT_OUT:   begin d.is_out = 1'b1; d.waits = 1'b1; end
         `PIOS_OP_IN_RESEL:   begin d.is_in = 1'b1; d.resel = 1'b1; end
         `PIOS_OP_OUT_RESEL:  begin d.is_out = 1'b1; d.resel = 1'b1; end
         `PIOS_OP_WIN_RESEL:  begin d.is_in = 1'b1; d.waits = 1'b1; d.resel = 1'b1; end
         `PIOS_OP_WOUT_RESEL: begin d.is_out = 1'b1; d.waits = 1'b1; d.resel = 1'b1; end
         `PIOS_OP_SENSE_A:    begin d.sense = 1'b1; d.resel = 1'b1; end
         `PIOS_OP_WSENSE_A:   begin d.sense = 1'b1; d.waits = 1'b1; d.resel = 1'b1; end
         `PIOS_OP_SENSE_B:    begin d.sense = 1'b1; d.cond_b = 1'b1; d.resel = 1'b1; end
         `PIOS_OP_WSENSE_B:   begin
            d.sense = 1'b1;
            d.cond_b = 1'b1;
            d.waits = 1'b1;
            d.resel = 1'b1;
         end
         default:             d = '0;
      endcase
      return d;
   endfunction

   typedef enum logic {PIOS_RUN, PIOS_SPIN} pios_state_e;

   pios_state_e                 state;
   logic [`PIOS_OP_W-1:0]       held_op;
   logic [SEL_W-1:0]            held_res;
   logic [DATA_W-1:0]           held_pad;
   logic [`PIOS_OP_W-1:0]       cur_op;
   logic [SEL_W-1:0]            cur_res;
   logic [DATA_W-1:0]           cur_pad;
   logic                        cur_live;
   pios_pkg::pios_dec_s         dec;
   logic                        gated_ready;
   logic                        fire;
   logic                        next_spin;
   logic [PANEL_W-1:0]          lamp_q;
   logic [PANEL_W-1:0]          switch_q;
   logic [PANEL_W-1:0]          func_q;
   pios_pkg::pios_pnl_e         pnl_op;
   logic                        wb_req;
   logic                        wb_hit;
   logic                        sw_we;
   logic                        fn_we;
   logic [31:0]                 next_rdata;

   // While spinning the held instruction is re-evaluated every cycle
   always_comb begin
      cur_live = (state == PIOS_SPIN) || op_valid;
      cur_op   = (state == PIOS_SPIN) ? held_op : op;
      cur_res  = (state == PIOS_SPIN) ? held_res : scratch_function_result;
      cur_pad  = (state == PIOS_SPIN) ? held_pad : pad_bus;
      dec      = cur_live ? decode(cur_op) : '0;
   end

   // Sense forms gate condition A or B; others use the target flag
   always_comb begin
      if (dec.sense) begin
         gated_ready = dec.cond_b ? cond_b : cond_a;
      end else begin
         gated_ready = target_ready_flag;
      end
   end

   // Waiting ops fire only on ready; plain ones fire at once
   assign fire      = cur_live && (!dec.waits || gated_ready);
   assign next_spin = cur_live && dec.waits && !gated_ready;

   // ----------
   // Sequencer
   // ----------

   // No timeout counter: a target that never raises ready stalls forever
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= PIOS_RUN;
      end else begin
         state <= next_spin ? PIOS_SPIN : PIOS_RUN;
      end
   end

   // Capture the stalled instruction and its operands on entry
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         held_op  <= `PIOS_OP_NOP;
         held_res <= `PIOS_SEL_RST;
         held_pad <= '0;
      end else if (state == PIOS_RUN && next_spin) begin
         held_op  <= op;
         held_res <= scratch_function_result;
         held_pad <= pad_bus;
      end
   end

   // Stall tells the pipeline to freeze all other program work
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         stall   <= 1'b0;
         op_done <= 1'b0;
      end else begin
         stall   <= next_spin;
         op_done <= fire;
      end
   end

   // Select register: new value seen from the next cycle onward
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         io_target_select_reg <= `PIOS_SEL_RST;
      end else if (op_valid && state == PIOS_RUN && op == `PIOS_OP_LOAD_SEL) begin
         io_target_select_reg <= pad_bus[SEL_W-1:0];
      end else if (fire && dec.resel) begin
         io_target_select_reg <= cur_res;
      end
   end

   // Output drives only in output cycles to avoid bus contention
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         shared_io_bus_out <= '0;
         shared_io_bus_oe  <= 1'b0;
      end else begin
         shared_io_bus_oe <= fire && dec.is_out;
         if (fire && dec.is_out) shared_io_bus_out <= cur_pad;
      end
   end

   // Input samples the bus only in input cycles
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pad_bus_in       <= '0;
         pad_bus_in_valid <= 1'b0;
         io_in_strobe     <= 1'b0;
      end else begin
         pad_bus_in_valid <= fire && (dec.is_in || cur_op == `PIOS_OP_SWITCH_RD);
         io_in_strobe     <= fire && dec.is_in;
         if (fire && dec.is_in) pad_bus_in <= shared_io_bus_alt;
         if (fire && cur_op == `PIOS_OP_SWITCH_RD) pad_bus_in <= DATA_W'(switch_q);
      end
   end

   // ----------
   // Panel
   // ----------

   pios_panel #(
      .PANEL_W (PANEL_W)
   ) u_panel (
      .mclk               (mclk),
      .sys_rst            (sys_rst),
      .host_sw_we         (sw_we),
      .host_fn_we         (fn_we),
      .host_wdata         (wb_dat_i[PANEL_W-1:0]),
      .cpu_lamp_we        (op_valid && state == PIOS_RUN && op == `PIOS_OP_LAMP_WR),
      .cpu_lamp_data      (pad_bus[PANEL_W-1:0]),
      .lamp_display_reg   (lamp_q),
      .switch_entry_reg   (switch_q),
      .panel_function_reg (func_q),
      .panel_op           (pnl_op)
   );

   // Switch read is answered on the input path; lamp registered out
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lamps         <= `PIOS_PANEL_RST;
         panel_op_code <= 3'h0;
      end else begin
         lamps         <= lamp_q;
         panel_op_code <= 3'(pnl_op);
      end
   end

   // ----------
   // Wishbone slave
   // ----------

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wb_hit = (wb_adr_i == `PIOS_ADR_SWITCH) || (wb_adr_i == `PIOS_ADR_LAMP) ||
                   (wb_adr_i == `PIOS_ADR_FUNC) || (wb_adr_i == `PIOS_ADR_STATUS);
   // Host owns switches and function; lamps are read-only to it
   assign sw_we  = wb_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1] &&
                   wb_adr_i == `PIOS_ADR_SWITCH;
   assign fn_we  = wb_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1] &&
                   wb_adr_i == `PIOS_ADR_FUNC;

   // Read mux; status shows select, spin state and ready
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `PIOS_ADR_SWITCH: next_rdata[PANEL_W-1:0] = switch_q;
         `PIOS_ADR_LAMP:   next_rdata[PANEL_W-1:0] = lamp_q;
         `PIOS_ADR_FUNC:   begin
            next_rdata[PANEL_W-1:0] = func_q;
            next_rdata[`PIOS_FN_STOP] = func_q[`PIOS_FN_STOP] && !stall;
         end
         `PIOS_ADR_STATUS: next_rdata[SEL_W+1:0] = {target_ready_flag, stall,
                                                    io_target_select_reg};
         default:          next_rdata = 32'h0000_0000;
      endcase
   end

   // One-cycle ack, error on unmapped address
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req && wb_hit;
         wb_err_o <= wb_req && !wb_hit;
         if (wb_req && !wb_we_i) wb_dat_o <= next_rdata;
      end
   end

endmodule

// [tb/pios_target_model.sv]
// Behavioural model of the addressed I/O targets on the shared bus.
// Assumes the block's select and strobes; the bench sets the busy time.
`timescale 1ns/1ns
module pios_target_model #(
   parameter int SEL_W  = 8,
   parameter int DATA_W = 16
) (
   // Clock and reset
   input wire logic              mclk,
   input wire logic              sys_rst,
   // From the block
   input wire logic [SEL_W-1:0]  sel,
   input wire logic [DATA_W-1:0] bus_out,
   input wire logic              bus_oe,
   input wire logic              in_strobe,
   // Bench control and observation
   input wire logic [3:0]        delay,
   output logic [DATA_W-1:0]     word,
   output logic                  ready,
   output logic                  cond_a,
   output logic                  cond_b,
   output logic [DATA_W-1:0]     rx_word,
   output logic [SEL_W-1:0]      rx_sel
);
   logic [3:0]       cnt;
   logic [SEL_W-1:0] last_sel;
   // Each target answers with a word built from its own number
   assign word   = DATA_W'({sel, ~sel});
   // Busy for delay cycles after a reselect or transfer; B inverts A to tell them apart
   assign ready  = cnt >= delay;
   assign cond_a = ready;
   assign cond_b = !ready;
   // Busy count; each output word is logged with the target selected at its fire edge
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt      <= 4'h0;
         last_sel <= '0;
         rx_word  <= '0;
         rx_sel   <= '0;
      end else begin
         last_sel <= sel;
         if (sel != last_sel || bus_oe || in_strobe) begin
            cnt <= 4'h0;
         end else if (cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
         end
         if (bus_oe) begin
            rx_word <= bus_out;
            rx_sel  <= last_sel;
         end
      end
   end
endmodule

// [tb/pios_top_asserts.sv]
// Checker on the block's ports: transfers, spins and the select register.
// Assumes the pios_top ports and the opcode map of pios_map.svh.
`timescale 1ns/1ns
`include "pios_map.svh"
module pios_top_asserts #(
   parameter int SEL_W  = 8,
   parameter int DATA_W = 16
) (
   // Clock, reset and instruction side
   input wire logic                  mclk,
   input wire logic                  sys_rst,
   input wire logic                  op_valid,
   input wire logic [`PIOS_OP_W-1:0] op,
   input wire logic [SEL_W-1:0]      scratch_function_result,
   input wire logic [DATA_W-1:0]     pad_bus,
   input wire logic                  stall,
   input wire logic                  op_done,
   input wire logic [DATA_W-1:0]     pad_bus_in,
   input wire logic                  pad_bus_in_valid,
   // Target side
   input wire logic [SEL_W-1:0]      io_target_select_reg,
   input wire logic [DATA_W-1:0]     shared_io_bus_out,
   input wire logic                  shared_io_bus_oe,
   input wire logic [DATA_W-1:0]     shared_io_bus_alt,
   input wire logic                  target_ready_flag,
   // Wishbone handshake
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_ack_o,
   input wire logic                  wb_err_o
);
   // ----------
   // Helpers
   // ----------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic             fire;
   logic             is_wait;
   logic             spin_io;
   assign fire    = op_valid && !stall;
   assign is_wait = op inside {`PIOS_OP_WAIT_IN, `PIOS_OP_WAIT_OUT,
                               `PIOS_OP_WIN_RESEL, `PIOS_OP_WOUT_RESEL};
   // Sense waits watch the condition lines, so only transfer waits track ready
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         spin_io <= 1'b0;
      end else if (fire) begin
         spin_io <= is_wait;
      end
   end

   // ----------
   // Properties
   // ----------
   a_out_word: assert property (
      fire && op == `PIOS_OP_OUT |=> shared_io_bus_oe && op_done
      && shared_io_bus_out == $past(pad_bus)) else $error("output word not sent");
   a_in_word: assert property (
      fire && op == `PIOS_OP_IN |=> pad_bus_in_valid && !shared_io_bus_oe
      && pad_bus_in == $past(shared_io_bus_alt)) else $error("input word not taken");
   a_plain_go: assert property (
      fire && (op == `PIOS_OP_IN || op == `PIOS_OP_OUT) |=> op_done && !stall)
      else $error("plain transfer waited");
   a_spin_enter: assert property (
      fire && is_wait && !target_ready_flag |=> stall && !op_done)
      else $error("wait op did not spin");
   a_spin_hold: assert property (
      stall && spin_io && !target_ready_flag |=> stall) else $error("spin ended early");
   a_spin_quiet: assert property (
      stall |-> !shared_io_bus_oe && !pad_bus_in_valid && !op_done)
      else $error("activity during spin");
   a_spin_exit: assert property (
      stall && spin_io && target_ready_flag |=> op_done && !stall)
      else $error("spin did not end on ready");
   a_resel_now: assert property (
      fire && (op == `PIOS_OP_IN_RESEL || op == `PIOS_OP_OUT_RESEL) |=> op_done
      && io_target_select_reg == $past(scratch_function_result)) else $error("no reselect");
   a_load_sel: assert property (
      fire && op == `PIOS_OP_LOAD_SEL |=> io_target_select_reg == $past(pad_bus[SEL_W-1:0]))
      else $error("select not loaded");
   a_sel_steady: assert property (
      !fire && !stall |=> $stable(io_target_select_reg)) else $error("select drifted");
   a_wb_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> (wb_ack_o != wb_err_o)
      ##1 !(wb_ack_o || wb_err_o)) else $error("bus answer timing wrong");
   c_spin_done: cover property (stall && spin_io ##1 op_done);
   c_sense_b: cover property (fire && op == `PIOS_OP_WSENSE_B);
   c_wb_err: cover property (wb_err_o);
endmodule
bind pios_top pios_top_asserts #(.SEL_W(SEL_W), .DATA_W(DATA_W)) i_chk (.*);

// [tb/tb.sv]
// Bench for the programmed I/O select block: instruction sequences and panel access.
// Assumes the design, target model and bound checker are compiled first.
`timescale 1ns/1ns
`include "pios_map.svh"
module tb;
   // ----------
   // Signals and tables
   // ----------
   logic        mclk, sys_rst, op_valid, stall, op_done, in_valid, oe, in_strobe, err;
   logic        ready, cond_a, cond_b, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, spun;
   logic [3:0]  op, wb_adr, wb_sel, dly;
   logic [7:0]  scr, sel, rx_sel, exp_sel, old;
   logic [15:0] pad_bus, pad_in, bus_out, bus_alt, lamps, rx_word, pd;
   logic [31:0] wb_wd, wb_rd, rd;
   logic [2:0]  pnl;
   int          n_mismatch, comparisons, cycles;
   logic [3:0]  codes [12] = '{`PIOS_OP_IN, `PIOS_OP_OUT, `PIOS_OP_WAIT_IN,
      `PIOS_OP_WAIT_OUT, `PIOS_OP_IN_RESEL, `PIOS_OP_OUT_RESEL, `PIOS_OP_WIN_RESEL,
      `PIOS_OP_WOUT_RESEL, `PIOS_OP_SENSE_A, `PIOS_OP_SENSE_B, `PIOS_OP_WSENSE_A,
      `PIOS_OP_WSENSE_B};

   pios_top i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid), .op(op),
      .scratch_function_result(scr), .pad_bus(pad_bus), .stall(stall), .op_done(op_done),
      .pad_bus_in(pad_in), .pad_bus_in_valid(in_valid), .io_target_select_reg(sel),
      .shared_io_bus_out(bus_out), .shared_io_bus_oe(oe), .io_in_strobe(in_strobe),
      .shared_io_bus_alt(bus_alt), .target_ready_flag(ready), .cond_a(cond_a),
      .cond_b(cond_b), .lamps(lamps), .panel_op_code(pnl), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .wb_err_o(wb_err));
   pios_target_model i_tgt (
      .mclk(mclk), .sys_rst(sys_rst), .sel(sel), .bus_out(bus_out), .bus_oe(oe),
      .in_strobe(in_strobe), .delay(dly), .word(bus_alt), .ready(ready),
      .cond_a(cond_a), .cond_b(cond_b), .rx_word(rx_word), .rx_sel(rx_sel));

   // ----------
   // Tasks
   // ----------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Classic single cycle; waits for ack or err, then drops the request for a cycle
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_wd  <= wd;
      do @(posedge mclk); while (wb_ack !== 1'b1 && wb_err !== 1'b1);
      rd = wb_rd;
      err = wb_err;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask
   // One instruction, then NOPs until done, so no op lands on a spin's first edge
   task automatic do_op(input logic [3:0] c, input logic [15:0] p, input logic [7:0] s,
                        input int lim);
      int k;
      @(posedge mclk);
      op_valid <= 1'b1;
      op       <= c;
      pad_bus  <= p;
      scr      <= s;
      @(posedge mclk);
      op_valid <= 1'b0;
      op       <= `PIOS_OP_NOP;
      spun = 1'b0;
      k = 0;
      #1;
      while (op_done !== 1'b1 && k < lim) begin
         spun |= (stall === 1'b1);
         @(posedge mclk);
         #1;
         k++;
      end
   endtask
   task automatic results();
      if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ----------
   // Clock, timeout and sequence
   // ----------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // A hung spin ends the run far past the hundred or so cycles needed
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      {op_valid, op, pad_bus, scr, dly, wb_cyc, wb_stb, wb_we, wb_adr, wb_wd} = '0;
      wb_sel = 4'hf;
      sys_rst = 1'b1;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      check("select reset", sel, 8'h00);
      // Boundary and ordinary target numbers, each usable by the next instruction
      for (int b = 0; b < 2; b++) begin
         exp_sel = b ? 8'ha5 : 8'hff;
         do_op(`PIOS_OP_LOAD_SEL, {8'h00, exp_sel}, 8'h00, 1);
         check("loaded select", sel, exp_sel);
      end
      // Every transfer, reselect and sense form, busy targets where it matters
      for (int i = 0; i < 12; i++) begin
         dly = (i < 8) ? 4'h5 : (i < 10) ? 4'h0 : 4'h4;
         pd = 16'hc000 | 16'(i);
         old = exp_sel;
         do_op(codes[i], pd, 8'h30 + 8'(i), 40);
         check("done", op_done, 1'b1);
         check("spin", spun, (i inside {2, 3, 6, 7, 10}) && dly != 4'h0);
         if (i inside {0, 2, 4, 6}) check("in word", {in_valid, pad_in}, {1'b1, old, ~old});
         if (i inside {1, 3, 5, 7}) check("out word", {oe, bus_out}, {1'b1, pd});
         if (i >= 4) exp_sel = 8'h30 + 8'(i);
         @(posedge mclk);
         #1;
         check("select", sel, exp_sel);
         if (i inside {1, 3, 5, 7}) check("target rx", {rx_sel, rx_word}, {old, pd});
      end
      // Lamps come from instructions only; a host write there is ignored
      do_op(`PIOS_OP_LAMP_WR, 16'hbeef, 8'h00, 1);
      wb(1'b1, `PIOS_ADR_LAMP, 32'h0000_1111);
      wb(1'b0, `PIOS_ADR_LAMP, 32'h0000_0000);
      check("lamp read", rd, 32'h0000_beef);
      check("lamp pins", lamps, 16'hbeef);
      wb(1'b1, `PIOS_ADR_SWITCH, 32'hffff_a55a);
      wb(1'b0, `PIOS_ADR_SWITCH, 32'h0000_0000);
      check("switch read", rd, 32'h0000_a55a);
      do_op(`PIOS_OP_SWITCH_RD, 16'h0000, 8'h00, 1);
      check("cpu switch", {in_valid, pad_in}, {1'b1, 16'ha55a});
      dly = 4'h0;
      wb(1'b0, `PIOS_ADR_STATUS, 32'h0000_0000);
      check("status", rd, {22'h0, 2'b10, exp_sel});
      wb(1'b0, 4'h2, 32'h0000_0000);
      check("unmapped err", err, 1'b1);
      // Stop outranks examine; the halt bit reads back once no spin runs
      wb(1'b1, `PIOS_ADR_FUNC, 32'h0000_0021);
      for (int k = 0; k < 8 && pnl !== 3'd1; k++) @(posedge mclk);
      check("panel op", pnl, 3'd1);
      wb(1'b1, `PIOS_ADR_FUNC, 32'h0000_0001);
      wb(1'b0, `PIOS_ADR_FUNC, 32'h0000_0000);
      check("halt bit", rd[0], 1'b1);
      results();
   end
endmodule
